// File: idb_pkg.sv
// idb_pkg: offsets, field positions, reset values and enums shared
// by the serial data buffer block and its helpers.
// assumes a byte-addressed classic wishbone register bus.
package idb_pkg;

    ////////////////////////////////////////////////////////////////////
    // register byte offsets; pairs share an address, enable picks one
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_FMT = 8'h04;
    localparam logic [7:0] OFS_CTL = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;

    ////////////////////////////////////////////////////////////////////
    // control register bits
    localparam int unsigned CTL_EN_BIT = 0;
    localparam int unsigned CTL_TRS_BIT = 1;
    localparam int unsigned CTL_MST_BIT = 2;
    localparam int unsigned CTL_W = 3;

    // status register bits
    localparam int unsigned ST_TXE_BIT = 0;
    localparam int unsigned ST_RXF_BIT = 1;
    localparam int unsigned ST_AAS_BIT = 2;
    localparam int unsigned ST_BUSY_BIT = 3;
    localparam int unsigned ST_GC_BIT = 4;

    // format/rate register and slave address fields
    localparam int unsigned FMT_ORDER_BIT = 7;
    localparam int unsigned FMT_BC_MSB = 2;
    localparam int unsigned SA_FMT_BIT = 0;
    localparam int unsigned SA_ADDR_LSB = 1;
    localparam int unsigned SA_ADDR_MSB = 7;

    ////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] SAR_RST = 8'h00;
    localparam logic [7:0] SECONDARY_SLAVE_ADDRESS_RST = 8'h01;
    localparam logic [7:0] FMT_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [2:0] CTL_RST = 3'h0;

    // frame figures
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [3:0] FULL_FRAME = 4'h8;
    localparam logic [2:0] BC_FULL = 3'h0;

    ////////////////////////////////////////////////////////////////////
    typedef enum logic {
        IDB_IDLE,
        IDB_BUSY
    } idb_phase_t;

endpackage

// File: idb_sync.sv
// idb_sync: two-flop synchroniser for one pin input.
// assumes d_i is asynchronous to clk_i; only q_o may be read.
`timescale 1ns/10ps
module idb_sync
    import idb_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin side
    input wire logic d_i,
    // synchronised level
    output logic q_o
);

    typedef struct packed {
        logic s1;
        logic s2;
    } idb_sync_t;

    idb_sync_t q, d;

    always_comb begin
        d.s1 = d_i;
        d.s2 = q.s1;
    end

    // idle bus is high, so reset to the released level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= {RST_VAL, RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign q_o = q.s2;

endmodule

// File: idb_addr_cmp.sv
// idb_addr_cmp: compares one slave address register with the
// first received frame.
// assumes frame_i holds address in bits 7..1, direction in bit 0.
`timescale 1ns/10ps
module idb_addr_cmp
    import idb_pkg::*;
(
    // address register and its enable
    input wire logic [7:0] addr_reg_i,
    input wire logic en_i,
    // received frame
    input wire logic [7:0] frame_i,
    // result
    output logic hit_o
);

    always_comb begin
        hit_o = en_i && (addr_reg_i[SA_ADDR_MSB:SA_ADDR_LSB] ==
                         frame_i[SA_ADDR_MSB:SA_ADDR_LSB]);
    end

endmodule

// File: idb_data_buffer.sv
// idb_data_buffer: byte data path and slave address recognition of
// one two-wire serial channel, with a wishbone register slave.
// assumes scl/sda pins are open-drain; clock generation, waits and
// arbitration live elsewhere; scl_i is slow against clk_i.
//
// Summary of operation
// [RULE_01] data register is a shifter plus receive and transmit buffers
// [RULE_02] master transmit: start condition discards earlier transmit data
// [RULE_03] software writes transmit data after start or address match
// [RULE_04] write transmit buffer only when empty; write clears empty flag
// [RULE_05] empty shifter loads transmit buffer and sets empty flag
// [RULE_06] busy shifter leaves new transmit data waiting in buffer
// [RULE_07] receive mode never loads shifter from transmit buffer
// [RULE_08] finished reception copies shifter to receive buffer, sets full
// [RULE_09] read received data only when full; read clears full flag
// [RULE_10] unread receive buffer keeps new data waiting in shifter
// [RULE_11] transmit mode never copies shifter into receive buffer
// [RULE_12] short transmit frames: justify by bit order select
// [RULE_13] short receive frames: low end msb-first, high end lsb-first
// [RULE_14] data register reachable only while interface enabled
// [RULE_15] primary address matches first frame when its format bit is 0
// [RULE_16] secondary address matches first frame when its format bit is 0
// [RULE_17] slave address registers reachable only while interface disabled
// [RULE_18] two format bits pick addresses, general call or synchronous
// [RULE_19] keep primary format bit 0 to recognise general call
// [RULE_20] synchronous format: no address, no acknowledge, master only; here it also frames with the master bit at 0
// [RULE_21] address in bits 7..1, format bit 0; secondary format resets 1
// [RULE_22] enable bit selects data or secondary, format or primary
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module idb_data_buffer
    import idb_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // two-wire link
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

    typedef struct packed {
        logic scl_d;
        logic sda_d;
        idb_phase_t phase;
        logic [3:0] cnt;
        logic first;
        logic addressed;
        logic gcall;
        logic [7:0] sh;
        logic sh_full;
        logic [7:0] txb;
        logic tx_empty;
        logic [7:0] rxb;
        logic rx_full;
        logic [7:0] primary_slave_address;
        logic [7:0] secondary_slave_address;
        logic [7:0] fmt;
        logic [CTL_W-1:0] ctl;
        logic ack;
        logic [7:0] dat;
        logic sda_oe;
    } idb_state_t;

    idb_state_t q, d;

    logic scl_s, sda_s;
    logic hit_pri, hit_sec;
    logic sync_fmt, i2c_fmt, en, transmit_mode_bit, mst, order_lsb;
    logic start_c, stop_c, rise_c, fall_c, active_c;
    logic req_c, wr_c, rd_c, gc_hit;
    logic [3:0] nbits_c, total_c, cnt_inc;
    logic [7:0] stat_c;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    idb_sync #(.RST_VAL(1'b1)) u_sync_scl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(scl_i),
        .q_o(scl_s)
    );

    idb_sync #(.RST_VAL(1'b1)) u_sync_sda (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sda_i),
        .q_o(sda_s)
    );

    ////////////////////////////////////////////////////////////////////
    // address recognition, gated by the format bits
    idb_addr_cmp u_cmp_pri (
        .addr_reg_i(q.primary_slave_address),
        .en_i(!q.primary_slave_address[SA_FMT_BIT]), // RULE_15
        .frame_i(q.sh),
        .hit_o(hit_pri)
    );

    idb_addr_cmp u_cmp_sec (
        .addr_reg_i(q.secondary_slave_address),
        .en_i(!q.secondary_slave_address[SA_FMT_BIT]), // RULE_16
        .frame_i(q.sh),
        .hit_o(hit_sec)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        sync_fmt = q.primary_slave_address[SA_FMT_BIT] && q.secondary_slave_address[SA_FMT_BIT]; // RULE_18
        i2c_fmt = !sync_fmt;
        // general call only while primary format bit is 0
        gc_hit = !q.primary_slave_address[SA_FMT_BIT] &&
                 (q.sh[SA_ADDR_MSB:SA_ADDR_LSB] == GEN_CALL_ADDR); // RULE_18
        en = q.ctl[CTL_EN_BIT];
        transmit_mode_bit = q.ctl[CTL_TRS_BIT];
        mst = q.ctl[CTL_MST_BIT];
        order_lsb = q.fmt[FMT_ORDER_BIT];
        nbits_c = (q.fmt[FMT_BC_MSB:0] == BC_FULL) ? FULL_FRAME :
                  {1'b0, q.fmt[FMT_BC_MSB:0]};
        // acknowledge slot only in the addressing format
        total_c = nbits_c + {3'h0, i2c_fmt}; // RULE_20
        cnt_inc = q.cnt + 4'h1;
        rise_c = scl_s && !q.scl_d;
        fall_c = !scl_s && q.scl_d;
        start_c = i2c_fmt && scl_s && q.scl_d && q.sda_d && !sda_s;
        stop_c = i2c_fmt && scl_s && q.scl_d && !q.sda_d && sda_s;
        // synchronous format has no start, so it is always framing
        active_c = (q.phase == IDB_BUSY) || sync_fmt;
        req_c = cyc_i && stb_i;
        wr_c = req_c && q.ack && we_i && sel_i[0];
        rd_c = req_c && q.ack && !we_i;
        stat_c = 8'h00;
        stat_c[ST_TXE_BIT] = q.tx_empty;
        stat_c[ST_RXF_BIT] = q.rx_full;
        stat_c[ST_AAS_BIT] = q.addressed;
        stat_c[ST_BUSY_BIT] = (q.phase == IDB_BUSY);
        stat_c[ST_GC_BIT] = q.gcall;
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        d.scl_d = scl_s;
        d.sda_d = sda_s;

        // bus: data latched at the first cycle, act when ack is seen
        d.ack = req_c && !q.ack;
        if (req_c && !q.ack) begin
            case (adr_i)
                OFS_DATA: d.dat = en ? q.rxb : q.secondary_slave_address; // RULE_22
                OFS_FMT: d.dat = en ? q.fmt : q.primary_slave_address; // RULE_22
                OFS_CTL: d.dat = {5'h00, q.ctl};
                OFS_STAT: d.dat = stat_c;
                default: d.dat = 8'h00;
            endcase
        end
        if (wr_c) begin
            case (adr_i)
                OFS_DATA: begin
                    if (!en) begin
                        d.secondary_slave_address = dat_i[7:0]; // RULE_17
                    end else if (transmit_mode_bit) begin
                        d.txb = dat_i[7:0]; // RULE_14
                        d.tx_empty = 1'b0; // RULE_04
                    end
                end
                OFS_FMT: begin
                    if (en) begin
                        d.fmt = dat_i[7:0];
                    end else begin
                        d.primary_slave_address = dat_i[7:0]; // RULE_17
                    end
                end
                OFS_CTL: d.ctl = dat_i[CTL_W-1:0];
                default: d.ctl = q.ctl;
            endcase
        end
        // reading the data register frees the receive buffer
        if (rd_c && adr_i == OFS_DATA && en) begin
            d.rx_full = 1'b0; // RULE_09
        end

        // pending reception moves on once the buffer is free
        if (!transmit_mode_bit && q.sh_full && !q.rx_full) begin
            d.rxb = q.sh; // RULE_08
            d.rx_full = 1'b1; // RULE_10
            d.sh_full = 1'b0;
        end
        // a busy shifter leaves the written byte in the buffer
        if (transmit_mode_bit && !q.tx_empty && !q.sh_full && !start_c) begin // RULE_07
            d.sh = q.txb; // RULE_05
            d.sh_full = 1'b1; // RULE_06
            d.tx_empty = 1'b1; // RULE_01
        end

        // link engine
        if (start_c) begin
            d.phase = IDB_BUSY;
            d.cnt = 4'h0;
            d.first = 1'b1;
            d.addressed = 1'b0;
            d.gcall = 1'b0;
            d.sda_oe = 1'b0;
            if (!mst) begin
                d.ctl[CTL_TRS_BIT] = 1'b0;
            end else if (transmit_mode_bit) begin
                // stale bytes from before the start are dropped
                d.tx_empty = 1'b1; // RULE_02
                d.sh_full = 1'b0; // RULE_02
            end
        end else if (stop_c) begin
            d.phase = IDB_IDLE;
            d.cnt = 4'h0;
            d.first = 1'b0;
            d.addressed = 1'b0;
            d.sda_oe = 1'b0;
        end else if (active_c && rise_c && q.cnt < total_c) begin
            if (q.cnt < nbits_c && !transmit_mode_bit) begin
                // shift direction leaves short frames justified
                if (order_lsb) begin
                    d.sh = {sda_s, q.sh[7:1]}; // RULE_13
                end else begin
                    d.sh = {q.sh[6:0], sda_s}; // RULE_13
                end
            end
            d.cnt = cnt_inc;
            if (cnt_inc == total_c) begin
                d.cnt = 4'h0;
                d.first = 1'b0;
                if (transmit_mode_bit) begin
                    // a byte loaded in this very cycle survives the end
                    d.sh_full = d.sh_full && !q.sh_full; // RULE_05
                end else if (q.addressed || mst || sync_fmt) begin
                    d.sh_full = 1'b1; // RULE_11
                end
            end
        end else if (active_c && fall_c) begin
            d.sda_oe = 1'b0;
            if (transmit_mode_bit && q.sh_full && q.cnt < nbits_c) begin
                if (order_lsb) begin
                    d.sda_oe = !q.sh[0]; // RULE_12
                    d.sh = {1'b0, q.sh[7:1]};
                end else begin
                    d.sda_oe = !q.sh[7]; // RULE_12
                    d.sh = {q.sh[6:0], 1'b0};
                end
            end else if (i2c_fmt && q.cnt == nbits_c) begin
                if (q.first && !mst) begin
                    // address frame: answer and take the direction
                    d.addressed = hit_pri || hit_sec || gc_hit; // RULE_15
                    d.gcall = gc_hit;
                    d.sda_oe = hit_pri || hit_sec || gc_hit; // RULE_16
                    d.ctl[CTL_TRS_BIT] = (hit_pri || hit_sec) &&
                                         q.sh[0]; // RULE_03
                end else if (!transmit_mode_bit && (q.addressed || mst)) begin
                    d.sda_oe = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data register contents are undefined; cleared for a clean start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q.scl_d <= 1'b1;
            q.sda_d <= 1'b1;
            q.phase <= IDB_IDLE;
            q.cnt <= 4'h0;
            q.first <= 1'b0;
            q.addressed <= 1'b0;
            q.gcall <= 1'b0;
            q.sh <= DATA_RST;
            q.sh_full <= 1'b0;
            q.txb <= DATA_RST;
            q.tx_empty <= 1'b1;
            q.rxb <= DATA_RST;
            q.rx_full <= 1'b0;
            q.primary_slave_address <= SAR_RST; // RULE_21
            q.secondary_slave_address <= SECONDARY_SLAVE_ADDRESS_RST; // RULE_21
            q.fmt <= FMT_RST;
            q.ctl <= CTL_RST;
            q.ack <= 1'b0;
            q.dat <= 8'h00;
            q.sda_oe <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign dat_o = {24'h000000, q.dat};
    assign ack_o = q.ack;
    assign sda_o = 1'b0;
    assign sda_oe_o = q.sda_oe;

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_data_wr;
        wr_c && adr_i == OFS_DATA;
    endsequence

    sequence s_data_rd;
        rd_c && adr_i == OFS_DATA;
    endsequence

    a_tx_write_clears: assert property ( // RULE_04
        s_data_wr ##0 (en && transmit_mode_bit && q.tx_empty && !start_c) |=>
            !q.tx_empty
    ) else $error("transmit write did not clear empty flag");

    a_shift_load: assert property ( // RULE_05
        transmit_mode_bit && !q.tx_empty && !q.sh_full && !start_c |=>
            q.tx_empty && q.sh_full && q.sh == $past(q.txb)
    ) else $error("transmit buffer not moved into shifter");

    a_start_discard: assert property ( // RULE_02
        start_c && mst && transmit_mode_bit |=> q.tx_empty && !q.sh_full
    ) else $error("start did not discard transmit data");

    a_no_rx_load: assert property ( // RULE_07
        !transmit_mode_bit && !q.sh_full && !(active_c && rise_c) |=> !q.sh_full
    ) else $error("shifter loaded in receive mode");

    a_rx_copy: assert property ( // RULE_08
        !transmit_mode_bit && q.sh_full && !q.rx_full |=>
            q.rx_full && q.rxb == $past(q.sh)
    ) else $error("received byte not copied to buffer");

    a_rx_hold: assert property ( // RULE_10
        q.rx_full && !(rd_c && adr_i == OFS_DATA && en) |=>
            q.rx_full && $stable(q.rxb)
    ) else $error("unread receive buffer overwritten");

    a_rx_read: assert property ( // RULE_09
        (s_data_rd ##0 en && q.rx_full) |=> !q.rx_full
    ) else $error("read did not clear full flag");

    a_no_rx_tx: assert property ( // RULE_11
        transmit_mode_bit |=> $stable(q.rxb)
    ) else $error("receive buffer changed in transmit mode");

    a_sar_locked: assert property ( // RULE_17
        wr_c && en && adr_i == OFS_FMT |=> $stable(q.primary_slave_address)
    ) else $error("slave address written while enabled");

    a_sync_no_ack: assert property ( // RULE_20
        sync_fmt && !transmit_mode_bit |=> !q.sda_oe && !q.addressed
    ) else $error("acknowledge driven in synchronous format");

endmodule

// File: idb_link_master.sv
// idb_link_master: behavioural far master on the two-wire link.
// assumes open-drain lines with pull-ups; an output of 1 releases.
`timescale 1ns/10ps
module idb_link_master (
    // clock that paces the link
    input wire logic clk_i,
    // resolved data line
    input wire logic sda_i,
    // open-drain drives
    output logic scl_o,
    output logic sda_o
);

    ////////////////////////////////////////////////////////////
    // clock rests between frames, never free-runs
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // data falls while clock high
    task automatic start();
        sda_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b0;
        tick(2);
    endtask

    // data rises while clock high
    task automatic stop();
        sda_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b1;
        tick(4);
    endtask

    // 8 data bits msb first, then the acknowledge slot; 320 ns bits
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_o <= tx[i];
            tick(2);
            scl_o <= 1'b1;
            tick(4);
            rx[i] = sda_i;
            scl_o <= 1'b0;
            tick(2);
        end
        sda_o <= 1'b1;
        tick(6);
    endtask

endmodule

// File: testbench.sv
// testbench: register access and link traffic for idb_data_buffer.
// assumes idb_link_master stands for the far master on the link.
`timescale 1ns/10ps
module testbench
    import idb_pkg::*;
;
    typedef struct packed {
        logic [7:0] primary_slave_address;
        logic [7:0] secondary_slave_address;
        logic [7:0] adr;
        logic ack;
    } idb_row_t;

    localparam int NROW = 11;
    // primary, secondary, address frame, acknowledge expected
    localparam idb_row_t ROWS [NROW] = '{
        '{8'h54, 8'h66, 8'h54, 1'b1}, '{8'h54, 8'h66, 8'h66, 1'b1},
        '{8'h54, 8'h66, 8'h00, 1'b1}, '{8'h54, 8'h66, 8'h22, 1'b0},
        '{8'h54, 8'h67, 8'h66, 1'b0}, '{8'h54, 8'h67, 8'h54, 1'b1},
        '{8'h54, 8'h67, 8'h00, 1'b1}, '{8'h55, 8'h66, 8'h54, 1'b0},
        '{8'h55, 8'h66, 8'h66, 1'b1}, '{8'h55, 8'h66, 8'h00, 1'b0},
        '{8'h55, 8'h67, 8'h54, 1'b0}};

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic sda_o;
    logic sda_oe_o;
    logic m_scl;
    logic m_sda;
    wire logic sda_w;
    int miscompares = 0;
    int checks_done = 0;

    // pull-up wins unless someone pulls low
    assign sda_w = m_sda & ~sda_oe_o;
    always #20 clk_i = ~clk_i;

    idb_data_buffer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .scl_i(m_scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

    idb_link_master m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(m_scl),
        .sda_o(m_sda));

    ////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; waits for ack, never assumes its latency
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 40) begin
            miscompares++;
            $display("Error ack expected 1 seen 0");
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(nm, e, q);
    endtask

    task automatic fl(input string nm, input int b, input logic e);
        logic [7:0] q;
        wb(1'b0, OFS_STAT, 8'h00, q);
        chk(nm, {7'h0, e}, {7'h0, q[b]});
    endtask

    // addresses only change while disabled
    task automatic cfg(input logic [7:0] primary_slave_address, input logic [7:0] secondary_slave_address,
                       input logic [7:0] ctl);
        wr(OFS_CTL, 8'h00);
        wr(OFS_DATA, secondary_slave_address);
        wr(OFS_FMT, primary_slave_address);
        wr(OFS_CTL, ctl);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        logic [8:0] r;
        logic [7:0] b;
        do_reset();
        for (int i = 0; i < NROW; i++) begin
            cfg(ROWS[i].primary_slave_address, ROWS[i].secondary_slave_address, 8'h01);
            m.start();
            m.xfer({ROWS[i].adr, 1'b1}, r);
            chk("ack", {7'h0, ~ROWS[i].ack}, {7'h0, r[0]});
            if (ROWS[i].ack) begin
                fl("rx_full", ST_RXF_BIT, 1'b1);
                rc("rx data", OFS_DATA, ROWS[i].adr);
                fl("rx_full read", ST_RXF_BIT, 1'b0);
            end
            m.stop();
            $display("test row %0d done", i);
        end
        do_reset();
        rc("secondary rst", OFS_DATA, SECONDARY_SLAVE_ADDRESS_RST);
        rc("primary rst", OFS_FMT, SAR_RST);
        rc("status rst", OFS_STAT, 8'h01);
        rc("unmapped", 8'h10, 8'h00);
        chk("sda_o idle", 8'h00, {7'h0, sda_o});
        wr(OFS_DATA, 8'h3c);
        wr(OFS_FMT, 8'h5a);
        wr(OFS_CTL, 8'h01);
        rc("format rst", OFS_FMT, FMT_RST);
        wr(OFS_DATA, 8'h99);
        fl("tx_empty rx mode", ST_TXE_BIT, 1'b1);
        wr(OFS_CTL, 8'h00);
        rc("secondary", OFS_DATA, 8'h3c);
        rc("primary", OFS_FMT, 8'h5a);
        $display("test access done");
        cfg(8'h54, 8'h01, 8'h01);
        m.start();
        m.xfer({8'h54, 1'b1}, r);
        m.xfer({8'ha5, 1'b1}, r);
        chk("data ack", 8'h00, {7'h0, r[0]});
        fl("rx_full kept", ST_RXF_BIT, 1'b1);
        rc("rx kept", OFS_DATA, 8'h54);
        rc("rx retained", OFS_DATA, 8'ha5);
        m.stop();
        $display("test overrun done");
        // fresh start so no retained byte can reach the buffer
        do_reset();
        cfg(8'h54, 8'h01, 8'h01);
        m.start();
        m.xfer({8'h55, 1'b1}, r);
        wr(OFS_DATA, 8'hc3);
        fl("tx_empty load", ST_TXE_BIT, 1'b1);
        wr(OFS_DATA, 8'h3c);
        fl("tx_empty held", ST_TXE_BIT, 1'b0);
        m.xfer(9'h1fe, r);
        // written after the ack slot fell; no wait state, so the first
        // slot goes out released and the byte lands one slot late
        chk("tx byte 1", 8'h61, {1'b0, r[7:1]});
        fl("tx_empty reload", ST_TXE_BIT, 1'b1);
        fl("rx_full tx mode", ST_RXF_BIT, 1'b0);
        m.xfer(9'h1ff, r);
        chk("tx byte 2", 8'h3c, r[8:1]);
        m.stop();
        $display("test slave transmit done");
        wr(OFS_CTL, 8'h07);
        wr(OFS_DATA, 8'h77);
        wr(OFS_DATA, 8'h88);
        fl("tx_empty pending", ST_TXE_BIT, 1'b0);
        m.start();
        fl("tx_empty start", ST_TXE_BIT, 1'b1);
        m.stop();
        $display("test start discard done");
        // synchronous format, three-bit frames taken lsb first
        do_reset();
        cfg(8'h01, 8'h01, 8'h01);
        wr(OFS_FMT, 8'h83);
        m.start();
        m.xfer(9'h181, r);
        chk("sync no ack", 8'h01, {7'h0, r[0]});
        fl("rx_full sync", ST_RXF_BIT, 1'b1);
        wb(1'b0, OFS_DATA, 8'h00, b);
        chk("short rx", 8'h60, {b[7:5], 5'h00});
        $display("test short frame done");
        stop_test();
    end

    // whole run is a few thousand cycles; 10000 means a hang
    initial begin
        #400000;
        miscompares++;
        $display("Error watchdog expected done seen hang");
        stop_test();
    end

endmodule
